// >>> logic/nmcr_pkg.sv
// ****************************************************************
// Package: offsets, fields, reset values, carriers
// ****************************************************************
package nmcr_pkg;

   // Register byte addresses (printed offsets are not all multiples of four: index times four)
   localparam logic [7:0] AUX_MOD_INDEX      = 8'h28;
   localparam logic [7:0] TARGET_UNMODULATED_RES_CODE_INDEX       = 8'h29;
   localparam logic [7:0] RESISTIVE_AM_ENABLE_INDEX       = 8'h2a;
   localparam logic [7:0] AM_INDEX_INDEX     = 8'h40;
   localparam logic [7:0] STATUS_INDEX       = 8'h41;
   localparam logic [9:0] AUX_MOD_ADDR       = {AUX_MOD_INDEX, 2'b00};
   localparam logic [9:0] TARGET_UNMODULATED_RES_CODE_ADDR        = {TARGET_UNMODULATED_RES_CODE_INDEX, 2'b00};
   localparam logic [9:0] RESISTIVE_AM_ENABLE_ADDR        = {RESISTIVE_AM_ENABLE_INDEX, 2'b00};
   localparam logic [9:0] AM_INDEX_ADDR      = {AM_INDEX_INDEX, 2'b00};
   localparam logic [9:0] STATUS_ADDR        = {STATUS_INDEX, 2'b00};

   // Field positions of the auxiliary modulation register
   localparam int REG_AM_DIS_BIT   = 7;
   localparam int EXT_POL_BIT      = 6;
   localparam int EXT_EN_BIT       = 5;
   localparam int DRV_LM_BIT       = 4;
   localparam int RESISTIVE_AM_ENABLE_BIT       = 3;
   localparam int SHAPED_AM_BIT    = 2;
   localparam logic [7:0] AUX_MOD_WMASK = 8'hfc;

   // Passive target field positions
   localparam int PT_MOD_LSB   = 4;
   localparam int PT_UNMOD_LSB = 0;

   // Reset values and the high impedance code
   localparam logic [7:0] AUX_MOD_RESET  = 8'h10;
   localparam logic [7:0] TARGET_UNMODULATED_RES_CODE_RESET   = 8'h60;
   localparam logic [6:0] RESISTIVE_AM_ENABLE_RESET   = 7'h00;
   localparam logic [3:0] AM_INDEX_RESET = 4'h7;
   localparam logic [3:0] RES_HIGH_Z     = 4'hf;

   // Drive settings handed to the transmitter
   typedef struct packed {
      logic       regulator_am_on;
      logic [3:0] am_index_field;
      logic       shaped_regulator_am_on;
      logic       resistive_am_on;
      logic [6:0] resistive_am_res_code;
      logic       driver_loadmod_on;
      logic [3:0] target_modulated_res_code;
      logic [3:0] target_unmodulated_res_code;
      logic       driver_high_z;
   } nmcr_drive_t;

endpackage

// >>> logic/nmcr_regs.sv
// Contract
// - Bit 7 zero enables regulator AM
// - Bit 6 inverts external modulation pin
// - Bit 5 gates external modulation pin
// - Bit 4 driver load modulation, resets one
// - Bit 3 resistive AM, 7-bit code
// - Modulated code high nibble, unmodulated low
// - Code fifteen means driver high impedance; the code raises it only while target_active and bit 4 are set
// - Resistive code in separate register low bits
`timescale 1ns/1ps
module nmcr_regs (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 reset,
   // AHB-Lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   // Modulation inputs from the coder
   input  wire logic                 load_modulate,
   input  wire logic                 target_active,
   // Outputs
   output nmcr_pkg::nmcr_drive_t     drive,
   output logic                      ext_loadmod_pin
);

   // ****************************************************************
   // Register state
   // ****************************************************************
   // Software visible state
   logic [7:0] aux_modulation_settings;
   logic [7:0] passive_target_drive_resistance;
   logic [6:0] resistive_am_res_code;
   logic [3:0] am_index_field;
   // Write data phase bookkeeping
   logic       wr_pend;
   logic [9:0] wr_addr;
   // Two stage synchroniser for the modulation strobe
   logic       lm_sync1;
   logic       lm_sync;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   // Only the word index haddr[11:2] is decoded, so the bank aliases
   // every 4 KiB; narrow comparators were judged worth the aliasing.
   // The size field is not checked: software only moves whole words.
   wire        addr_take = hsel & hready & htrans[1];
   wire [9:0]  word_addr = haddr[11:2];
   wire [31:0] rd_word;
   wire        hit;

   // Index compare shared by the read mux and the write strobes
   function automatic logic index_is(input logic [9:0] a, input logic [7:0] idx);
      index_is = (a == {2'b00, idx});
   endfunction

   // Read mux: hit flag on top, zero extended register below
   function automatic logic [32:0] read_mux(input logic [9:0] a, input logic [7:0] aux, input logic [7:0] pt,
                                            input logic [6:0] ra, input logic [3:0] ai, input logic st);
      read_mux = {1'b0, 32'h00000000};
      if (index_is(a, nmcr_pkg::AUX_MOD_INDEX)) begin
         read_mux = {1'b1, 24'h000000, aux & nmcr_pkg::AUX_MOD_WMASK};
      end
      if (index_is(a, nmcr_pkg::TARGET_UNMODULATED_RES_CODE_INDEX)) begin
         read_mux = {1'b1, 24'h000000, pt};
      end
      if (index_is(a, nmcr_pkg::RESISTIVE_AM_ENABLE_INDEX)) begin
         read_mux = {1'b1, 25'h0000000, ra};
      end
      if (index_is(a, nmcr_pkg::AM_INDEX_INDEX)) begin
         read_mux = {1'b1, 28'h0000000, ai};
      end
      if (index_is(a, nmcr_pkg::STATUS_INDEX)) begin
         read_mux = {1'b1, 31'h00000000, st};
      end
   endfunction

   assign {hit, rd_word} = read_mux(word_addr, aux_modulation_settings, passive_target_drive_resistance,
                                    resistive_am_res_code, am_index_field, ext_loadmod_pin);

   // Write strobes from the index held over from the address phase
   wire        wr_aux = wr_pend & index_is(wr_addr, nmcr_pkg::AUX_MOD_INDEX);
   wire        wr_pt  = wr_pend & index_is(wr_addr, nmcr_pkg::TARGET_UNMODULATED_RES_CODE_INDEX);
   wire        wr_ra  = wr_pend & index_is(wr_addr, nmcr_pkg::RESISTIVE_AM_ENABLE_INDEX);
   wire        wr_ai  = wr_pend & index_is(wr_addr, nmcr_pkg::AM_INDEX_INDEX);

   // ****************************************************************
   // Bus response
   // ****************************************************************
   // Bus answers in zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Address phase capture; a write lands in the following data phase.
   // A read in the same cycle as a write data phase sees the old value.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wr_pend <= 1'b0;
         wr_addr <= 10'h000;
         hrdata  <= 32'h00000000;
      end else begin
         wr_pend <= addr_take & hwrite;
         wr_addr <= word_addr;
         hrdata  <= (addr_take & ~hwrite & hit) ? rd_word : 32'h00000000;
      end
   end

   // ****************************************************************
   // Register writes
   // ****************************************************************
   // Register writes in the data phase; unmapped writes are dropped
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         aux_modulation_settings         <= nmcr_pkg::AUX_MOD_RESET;
         passive_target_drive_resistance <= nmcr_pkg::TARGET_UNMODULATED_RES_CODE_RESET;
         resistive_am_res_code           <= nmcr_pkg::RESISTIVE_AM_ENABLE_RESET;
         am_index_field                  <= nmcr_pkg::AM_INDEX_RESET;
      end else begin
         if (wr_aux) begin
            aux_modulation_settings <= hwdata[7:0] & nmcr_pkg::AUX_MOD_WMASK;
         end
         if (wr_pt) begin
            passive_target_drive_resistance <= hwdata[7:0];
         end
         if (wr_ra) begin
            resistive_am_res_code <= hwdata[6:0];
         end
         if (wr_ai) begin
            am_index_field <= hwdata[3:0];
         end
      end
   end

   // ****************************************************************
   // Modulation outputs
   // ****************************************************************
   // Everything below is registered, so the transmitter never sees a
   // half written setting; the price is one cycle of extra latency.
   // From a change of the strobe to the pin there are three edges.
   // Modulation strobe arrives from another domain, so it is synchronised
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         lm_sync1 <= 1'b0;
         lm_sync  <= 1'b0;
      end else begin
         lm_sync1 <= load_modulate;
         lm_sync  <= lm_sync1;
      end
   end

   wire       ext_en  = aux_modulation_settings[nmcr_pkg::EXT_EN_BIT];
   wire       ext_pol = aux_modulation_settings[nmcr_pkg::EXT_POL_BIT];
   wire [3:0] pt_mod  = passive_target_drive_resistance[nmcr_pkg::PT_MOD_LSB +: 4];
   wire [3:0] pt_un   = passive_target_drive_resistance[nmcr_pkg::PT_UNMOD_LSB +: 4];
   wire       drv_lm  = aux_modulation_settings[nmcr_pkg::DRV_LM_BIT];
   wire [3:0] cur_res = lm_sync ? pt_mod : pt_un;

   // Registered pin; idle level follows polarity so it never glitches active
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ext_loadmod_pin <= 1'b0;
      end else begin
         ext_loadmod_pin <= (ext_en & lm_sync) ^ ext_pol;
      end
   end

   // Drive settings; inverted sense on the regulator AM bit
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         drive <= '0;
      end else begin
         drive.regulator_am_on             <= ~aux_modulation_settings[nmcr_pkg::REG_AM_DIS_BIT];
         drive.am_index_field              <= am_index_field;
         drive.shaped_regulator_am_on      <= aux_modulation_settings[nmcr_pkg::SHAPED_AM_BIT];
         drive.resistive_am_on             <= aux_modulation_settings[nmcr_pkg::RESISTIVE_AM_ENABLE_BIT];
         drive.resistive_am_res_code       <= resistive_am_res_code;
         drive.driver_loadmod_on           <= drv_lm;
         drive.target_modulated_res_code   <= pt_mod;
         drive.target_unmodulated_res_code <= pt_un;
         drive.driver_high_z               <= target_active & drv_lm & (cur_res == nmcr_pkg::RES_HIGH_Z);
      end
   end

endmodule

// >>> test/nmcr_properties.sv
`timescale 1ns/1ps
// ****
// Checker: shadows bus writes, ties drive and pin to them
// ****
module nmcr_properties (
   input wire logic                  sys_clk, reset, hsel, hwrite, hready, load_modulate, target_active,
   input wire logic [31:0]           haddr, hwdata, hrdata,
   input wire logic [1:0]            htrans,
   input wire logic                  ext_loadmod_pin,
   input wire nmcr_pkg::nmcr_drive_t drive
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic [7:0] aux, pt;
   logic [6:0] ra;
   logic [1:0] ok;
   logic       wq;
   logic [9:0] wa;
   wire  [9:0] a  = haddr[11:2];
   wire        tk = hsel && hready && htrans[1];
   // Shadow copy; ok delays checks past the first edges after reset
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         {aux, pt, ra, ok, wq, wa} <= {8'h10, 8'h60, 20'h0};
      end else begin
         ok <= {ok[0], 1'b1};
         wq <= tk && hwrite;
         wa <= a;
         if (wq && wa == 10'h028) aux <= hwdata[7:0] & 8'hfc;
         if (wq && wa == 10'h029) pt <= hwdata[7:0];
         if (wq && wa == 10'h02a) ra <= hwdata[6:0];
      end
   end
   sequence rd_s(x); tk && !hwrite && a == x; endsequence
   sequence lm_s; (ok[1] && $stable(load_modulate)) [*4]; endsequence
   regam_inv_a: assert property (ok[1] |-> drive.regulator_am_on == ~$past(aux[7])) else $error("reg am");
   drv_loadmod_a: assert property (ok[1] |-> drive.driver_loadmod_on == $past(aux[4])) else $error("drv lm");
   resistive_am_enable_a: assert property (ok[1] |-> {drive.resistive_am_on, drive.resistive_am_res_code} == $past({aux[3], ra}))
      else $error("resistive_am_enable");
   pt_codes_a: assert property (ok[1] |-> {drive.target_modulated_res_code, drive.target_unmodulated_res_code}
      == $past(pt)) else $error("pt codes");
   high_z_a: assert property (lm_s |-> drive.driver_high_z == $past(target_active && aux[4]
      && (load_modulate ? pt[7:4] : pt[3:0]) == 4'hf)) else $error("high z");
   ext_pin_a: assert property (lm_s |-> ext_loadmod_pin == $past((aux[5] & load_modulate) ^ aux[6]))
      else $error("ext pin");
   rd_aux_a: assert property (rd_s(10'h028) |=> hrdata == {24'h0, $past(aux)}) else $error("aux read");
   rd_pt_a: assert property (rd_s(10'h029) |=> hrdata == {24'h0, $past(pt)}) else $error("pt read");
endmodule
bind nmcr_regs nmcr_properties nmcr_properties_inst (.*);

// >>> test/nmcr_coder_model.sv
`timescale 1ns/1ps
// Far side: enters passive mode and modulates only on request
module nmcr_coder_model (
   input  wire logic sys_clk, want_passive, want_mod,
   output logic      target_active = 1'b0,
   output logic      load_modulate = 1'b0
);
   // Passive mode raised only after the bench has set both codes
   always @(posedge sys_clk) begin
      target_active <= want_passive;
      load_modulate <= want_mod;
   end
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
// ****
// Bench: AHB-Lite master, coder model, register tests
// ****
module tb;
   logic                  sys_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, pas = 1'b0, md = 1'b0;
   logic [31:0]           haddr = '0, hwdata = '0, rd;
   logic [1:0]            htrans = '0;
   wire  [31:0]           hrdata;
   wire                   hreadyout, hresp, target_active, load_modulate, ext_loadmod_pin;
   wire nmcr_pkg::nmcr_drive_t drive;
   int                    err_count = 0, compares = 0, cyc = 0;
   initial forever #2 sys_clk = ~sys_clk;
   // One slave, so its hreadyout is the bus hready
   nmcr_regs nmcr_regs_inst (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .load_modulate(load_modulate), .target_active(target_active),
      .drive(drive), .ext_loadmod_pin(ext_loadmod_pin));
   nmcr_coder_model nmcr_coder_model_inst (.sys_clk(sys_clk), .want_passive(pas), .want_mod(md),
      .target_active(target_active), .load_modulate(load_modulate));
   task automatic summarize;
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, exp, input string m);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Single word transfer; read data taken at the data phase edge
   task automatic bus(input logic w, input logic [31:0] ad, wd);
      @(posedge sys_clk);
      {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'b10, ad};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdc(input logic [31:0] ad, ex, input string m);
      bus(1'b0, ad, 32'h0);
      cmp(rd, ex, m);
   endtask
   // Hang guard, far above the roughly 140 cycles needed
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         summarize;
      end
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      rdc(32'ha0, 32'h10, "aux reset");
      rdc(32'ha4, 32'h60, "pt reset");
      rdc(32'ha8, 32'h0, "res reset");
      bus(1'b1, 32'h200, 32'hff);
      rdc(32'h200, 32'h0, "unmapped");
      cmp({hresp, hreadyout}, 32'h1, "bus okay");
      rdc(32'h100, 32'h7, "am index reset");
      cmp({drive.regulator_am_on, drive.driver_loadmod_on}, 32'h3, "drive reset");
      $display("test reset done");
      bus(1'b1, 32'ha0, 32'hff);
      rdc(32'ha0, 32'hfc, "aux reserved");
      cmp({drive.regulator_am_on, drive.shaped_regulator_am_on, drive.resistive_am_on,
         drive.driver_loadmod_on}, 32'h7, "aux on");
      bus(1'b1, 32'ha0, 32'h0);
      repeat (2) @(posedge sys_clk);
      cmp({drive.regulator_am_on, drive.shaped_regulator_am_on, drive.resistive_am_on,
         drive.driver_loadmod_on}, 32'h8, "aux off");
      $display("test aux done");
      bus(1'b1, 32'ha4, 32'hf5);
      bus(1'b1, 32'ha8, 32'h7f);
      bus(1'b1, 32'ha0, 32'h18);
      rdc(32'ha8, 32'h7f, "res code");
      cmp(drive.resistive_am_res_code, 32'h7f, "res drive");
      pas <= 1'b1;
      md <= 1'b1;
      repeat (6) @(posedge sys_clk);
      cmp({drive.target_modulated_res_code, drive.target_unmodulated_res_code, drive.driver_high_z},
         32'h1eb, "pt modulated");
      md <= 1'b0;
      repeat (6) @(posedge sys_clk);
      cmp({drive.target_modulated_res_code, drive.target_unmodulated_res_code, drive.driver_high_z},
         32'h1ea, "pt unmodulated");
      pas <= 1'b0;
      $display("test passive done");
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 32'ha0, {25'h0, i[1:0], 5'h0});
         md <= i[2];
         repeat (5) @(posedge sys_clk);
         cmp(ext_loadmod_pin, (i[0] & i[2]) ^ i[1], "ext pin");
      end
      $display("test pin done");
      summarize;
   end
endmodule
